// File: rtl/flash_status_pkg.sv
/*
 * constants for the flash status-register write and poll block.
 * assumes an spi mode 0/3 host; device clocked at 40 MHz.
 */
package flash_status_pkg;
    // -----------------------------------------------------------
    // opcodes
    // -----------------------------------------------------------
    localparam logic [7:0] OP_WRITE_STATUS_ONE = 8'h01;
    localparam logic [7:0] OP_WRITE_STATUS_TWO = 8'h31;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;
    // -----------------------------------------------------------
    // status byte fields
    // -----------------------------------------------------------
    localparam int BIT_READY_BUSY = 0;
    localparam int BIT_WRITE_ENABLE = 1;
    localparam int BIT_ARRAY_PROTECT = 2;
    localparam int BIT_WP_PIN = 4;
    localparam int BIT_ARRAY_ERROR = 5;
    localparam int BIT_PROTECT_LOCK = 7;
    localparam int BIT_SOFT_RESET = 4;
    localparam int BITS_PER_BYTE = 8;
    localparam logic [7:0] BYTE_TWO_RESERVED_VAL = 8'h00;
endpackage : flash_status_pkg

// File: rtl/flash_status_write_control.sv
/*
 * status-register write and poll logic of a serial flash device.
 * assumes an spi host in mode 0 or 3; sclk and chip select are
 * oversampled by CLK; the array engine reports busy and error.
 */
// How it works
// [RL1] host polls status until ready_busy_flag drops from one to zero
// [RL2] ready_busy_flag sits at bit 0 of both status bytes
// [RL3] reset command ignored while soft_reset_permit is zero
// [RL4] reset command acted on when soft_reset_permit is one
// [RL5] soft_reset_permit survives reset command; only write or power
// [RL6] only byte-two status write alters soft_reset_permit
// [RL7] byte-two write touches only positions 4 and 3; code loads position 4 only
// [RL8] host sets write enable before byte-one status write
// [RL9] opcode 01h, data bit 7 lock, bit 2 array protect
// [RL10] bytes after byte-one data are discarded
// [RL11] on deselect after valid 01h write, load bits, clear latch
// [RL12] protection change depends on new value, old lock, wp pin
// [RL13] partial byte-one write aborts, keeps bits, clears latch
// [RL14] with wp asserted, lock may only be set; clear attempt ignored
// [RL15] host sets write enable before byte-two status write
// [RL16] opcode 31h, data bit 4 reset permit, extra bytes discarded
// [RL17] on deselect after valid 31h write, load permit, clear latch
// [RL18] partial byte-two write keeps permit, still clears latch
// [RL19] opcode 05h streams byte one then two, msb first, repeating
// [RL20] status writes refused while write_enable_latch is zero
// [RL21] protect_lock_bit is zero after power-up
// [RL22] reserved byte-two positions read zero, ignore writes
`timescale 1ns/1ps
module flash_status_write_control (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CS_N,
    input wire logic SCLK,
    input wire logic SI,
    input wire logic WP_N,
    input wire logic ARRAY_BUSY,
    input wire logic ARRAY_ERROR,
    output logic SO,
    output logic SO_OE,
    output logic PROTECT_LOCK,
    output logic ARRAY_PROTECT,
    output logic WRITE_ENABLE,
    output logic SOFT_RESET_PERMIT,
    output logic SOFT_RESET_PULSE
);
    // -----------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------
    logic cs_n_s;
    logic sclk_s;
    logic si_s;
    logic wp_n_s;
    logic sclk_d;
    logic cs_n_d;

    pin_sync #(.RESET_VAL(1'b1)) u_cs (.clk(CLK), .rstn(RSTN),
        .async_in(CS_N), .level(cs_n_s));
    pin_sync #(.RESET_VAL(1'b0)) u_sclk (.clk(CLK), .rstn(RSTN),
        .async_in(SCLK), .level(sclk_s));
    pin_sync #(.RESET_VAL(1'b0)) u_si (.clk(CLK), .rstn(RSTN),
        .async_in(SI), .level(si_s));
    pin_sync #(.RESET_VAL(1'b1)) u_wp (.clk(CLK), .rstn(RSTN),
        .async_in(WP_N), .level(wp_n_s));

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            sclk_d <= 1'b0;
            cs_n_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            cs_n_d <= cs_n_s;
        end
    end

    logic rise;
    logic fall;
    logic cs_start;
    logic cs_end;
    assign rise = !cs_n_s && sclk_s && !sclk_d;
    assign fall = !cs_n_s && !sclk_s && sclk_d;
    assign cs_start = cs_n_d && !cs_n_s;
    assign cs_end = !cs_n_d && cs_n_s;

    // -----------------------------------------------------------
    // command shifter
    // -----------------------------------------------------------
    typedef enum {ST_OPCODE, ST_DATA, ST_IGNORE, ST_READ} state_t;
    state_t state;
    logic [2:0] bit_cnt;
    logic [6:0] shift;
    logic [7:0] opcode;
    logic [7:0] data;
    logic data_done;
    logic [7:0] next_byte;
    assign next_byte = {shift, si_s};

    function automatic logic is_status_write(input logic [7:0] op);
        return op == flash_status_pkg::OP_WRITE_STATUS_ONE ||
               op == flash_status_pkg::OP_WRITE_STATUS_TWO;
    endfunction : is_status_write

    always_ff @(posedge CLK) begin
        if (!RSTN || cs_start) begin
            bit_cnt <= 3'h0;
            shift <= 7'h00;
        end else if (rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            shift <= next_byte[6:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN || cs_start) begin
            state <= ST_OPCODE;
            opcode <= 8'h00;
            data <= 8'h00;
            data_done <= 1'b0;
        end else if (rise && bit_cnt == 3'h7) begin
            case (state)
                ST_OPCODE: begin
                    opcode <= next_byte;
                    if (next_byte == flash_status_pkg::OP_READ_STATUS) begin
                        state <= ST_READ; // see [RL19]
                    end else if (is_status_write(next_byte)) begin
                        state <= ST_DATA;
                    end else begin
                        state <= ST_IGNORE;
                    end
                end
                ST_DATA: begin
                    data <= next_byte;
                    data_done <= 1'b1;
                    state <= ST_IGNORE; // see [RL10] see [RL16]
                end
                ST_IGNORE: state <= ST_IGNORE;
                ST_READ: state <= ST_READ;
                default: state <= ST_IGNORE;
            endcase
        end
    end

    logic on_boundary;
    logic full_opcode;
    logic valid_write;
    assign on_boundary = bit_cnt == 3'h0;
    assign full_opcode = state != ST_OPCODE;
    assign valid_write = data_done && on_boundary && WRITE_ENABLE;

    // -----------------------------------------------------------
    // status bits
    // -----------------------------------------------------------
    logic new_lock;
    logic lock_clear_blocked;
    assign new_lock = data[flash_status_pkg::BIT_PROTECT_LOCK];
    assign lock_clear_blocked = !wp_n_s && PROTECT_LOCK && !new_lock;

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            PROTECT_LOCK <= 1'b0; // see [RL21]
            ARRAY_PROTECT <= 1'b0;
        end else if (cs_end && valid_write && state == ST_IGNORE
                && opcode == flash_status_pkg::OP_WRITE_STATUS_ONE
                && !lock_clear_blocked) begin // see [RL14]
            PROTECT_LOCK <= new_lock; // see [RL9] see [RL11]
            // lock with wp asserted freezes array protect
            if (!(PROTECT_LOCK && !wp_n_s)) begin // see [RL12]
                ARRAY_PROTECT <=
                    data[flash_status_pkg::BIT_ARRAY_PROTECT];
            end
        end
    end // see [RL13]

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            SOFT_RESET_PERMIT <= 1'b0; // see [RL3]
        end else if (cs_end && valid_write
                && opcode == flash_status_pkg::OP_WRITE_STATUS_TWO) begin
            SOFT_RESET_PERMIT <=
                data[flash_status_pkg::BIT_SOFT_RESET]; // see [RL6] see [RL17]
        end
    end // see [RL5] see [RL7] see [RL18]

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            WRITE_ENABLE <= 1'b0;
        end else if (cs_end && on_boundary && state == ST_IGNORE
                && opcode == flash_status_pkg::OP_WRITE_ENABLE) begin
            WRITE_ENABLE <= 1'b1;
        end else if (cs_end && full_opcode && (is_status_write(opcode)
                || opcode == flash_status_pkg::OP_WRITE_DISABLE)) begin
            WRITE_ENABLE <= 1'b0; // see [RL11] see [RL13] see [RL20]
        end
    end

    // -----------------------------------------------------------
    // reset command gate
    // -----------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            SOFT_RESET_PULSE <= 1'b0;
        end else begin
            SOFT_RESET_PULSE <= cs_end && on_boundary && SOFT_RESET_PERMIT
                && state == ST_IGNORE
                && opcode == flash_status_pkg::OP_RESET; // see [RL3] see [RL4]
        end
    end

    // -----------------------------------------------------------
    // status readout
    // -----------------------------------------------------------
    logic [7:0] byte_one;
    logic [7:0] byte_two;
    logic [7:0] out_byte;
    logic out_sel;
    logic [2:0] out_cnt;

    always_comb begin
        byte_one = 8'h00;
        byte_one[flash_status_pkg::BIT_PROTECT_LOCK] = PROTECT_LOCK;
        byte_one[flash_status_pkg::BIT_ARRAY_ERROR] = ARRAY_ERROR;
        byte_one[flash_status_pkg::BIT_WP_PIN] = wp_n_s;
        byte_one[flash_status_pkg::BIT_ARRAY_PROTECT] = ARRAY_PROTECT;
        byte_one[flash_status_pkg::BIT_WRITE_ENABLE] = WRITE_ENABLE;
        byte_one[flash_status_pkg::BIT_READY_BUSY] = ARRAY_BUSY; // see [RL2]
        byte_two = flash_status_pkg::BYTE_TWO_RESERVED_VAL; // see [RL22]
        byte_two[flash_status_pkg::BIT_SOFT_RESET] = SOFT_RESET_PERMIT;
        byte_two[flash_status_pkg::BIT_READY_BUSY] = ARRAY_BUSY; // see [RL2]
    end

    // capture fresh byte at each byte start so polling sees new data
    always_ff @(posedge CLK) begin
        if (!RSTN || cs_start) begin
            out_sel <= 1'b0;
            out_cnt <= 3'h0;
            out_byte <= 8'h00;
        end else if (state == ST_READ && fall) begin
            if (out_cnt == 3'h0) begin
                out_byte <= out_sel ? {byte_two[6:0], 1'b0}
                                    : {byte_one[6:0], 1'b0};
                out_sel <= !out_sel; // see [RL1] see [RL19]
            end else begin
                out_byte <= {out_byte[6:0], 1'b0};
            end
            out_cnt <= out_cnt + 3'h1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN || cs_n_s) begin
            SO <= 1'b0;
            SO_OE <= 1'b0;
        end else if (state == ST_READ && fall) begin
            SO_OE <= 1'b1;
            if (out_cnt == 3'h0) begin
                SO <= out_sel ? byte_two[7] : byte_one[7];
            end else begin
                SO <= out_byte[7];
            end
        end
    end
endmodule : flash_status_write_control

// File: rtl/pin_sync.sv
/*
 * three-stage synchroniser with agreement of the last two stages.
 * assumes an asynchronous input and a single clock domain.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic async_in,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s1 <= RESET_VAL;
            s2 <= RESET_VAL;
            s3 <= RESET_VAL;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // change counts once second and third agree
    always_ff @(posedge clk) begin
        if (!rstn) begin
            level <= RESET_VAL;
        end else if (s2 == s3) begin
            level <= s3;
        end
    end
endmodule : pin_sync

// File: tb/flash_status_write_control_monitor.sv
/* port checker for the flash status write block.
   assumes binding onto flash_status_write_control. */
`timescale 1ns/1ps
module flash_status_write_control_monitor (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CS_N,
    input wire logic WP_N,
    input wire logic SO_OE,
    input wire logic PROTECT_LOCK,
    input wire logic ARRAY_PROTECT,
    input wire logic WRITE_ENABLE,
    input wire logic SOFT_RESET_PERMIT,
    input wire logic SOFT_RESET_PULSE
);
    // ---------------------------------------------------------
    // port relations
    // ---------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    chk_permit_on_deselect: assert property (
        $changed(SOFT_RESET_PERMIT) |-> CS_N && $past(CS_N, 3))
        else $error("permit changed while selected");
    chk_permit_clears_latch: assert property (
        $changed(SOFT_RESET_PERMIT) |-> ##[0:2] !WRITE_ENABLE)
        else $error("latch kept after permit write");
    chk_write_needs_latch: assert property (
        $rose(SOFT_RESET_PERMIT) || $rose(ARRAY_PROTECT)
        |-> $past(WRITE_ENABLE, 3))
        else $error("write taken without latch");
    chk_protect_on_deselect: assert property (
        $changed(PROTECT_LOCK) || $changed(ARRAY_PROTECT) |-> CS_N)
        else $error("protection changed while selected");
    chk_pulse_single: assert property (
        SOFT_RESET_PULSE |=> !SOFT_RESET_PULSE)
        else $error("reset pulse too long");
    chk_pulse_gated: assert property (
        SOFT_RESET_PULSE |-> SOFT_RESET_PERMIT && CS_N)
        else $error("reset acted without permit");
    chk_permit_kept: assert property (
        SOFT_RESET_PULSE |=> SOFT_RESET_PERMIT [*4])
        else $error("reset altered permit");
    chk_wp_lock_hold: assert property (
        $fell(PROTECT_LOCK) |-> WP_N && $past(WP_N, 8))
        else $error("lock cleared under write protect");
    chk_so_released: assert property (
        $rose(CS_N) |-> ##[1:8] !SO_OE)
        else $error("output kept driving after deselect");
endmodule : flash_status_write_control_monitor

bind flash_status_write_control flash_status_write_control_monitor mon (
    .CLK, .RSTN, .CS_N, .WP_N, .SO_OE, .PROTECT_LOCK, .ARRAY_PROTECT,
    .WRITE_ENABLE, .SOFT_RESET_PERMIT, .SOFT_RESET_PULSE);

// File: tb/flash_status_write_control_tb.sv
/* self-checking bench for the flash status write block.
   assumes spi_host_model as host and the bound port checker. */
`timescale 1ns/1ps
module flash_status_write_control_tb;
    logic clk, rstn, cs_n, sclk, si, wp_n, busy, err;
    logic so, so_oe, so_line, lock, bp, wr_en, permit, pulse;
    int failures = 0;
    int total_checks = 0;
    int pulses = 0;
    // ---------------------------------------------------------
    // harness
    // ---------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) if (pulse === 1'b1) pulses <= pulses + 1;
    // released output floats to its pull-up level at the host
    assign so_line = so_oe ? so : 1'b1;
    spi_host_model host (.clk(clk), .so(so_line), .cs_n(cs_n),
        .sclk(sclk), .si(si));
    flash_status_write_control dut (.CLK(clk), .RSTN(rstn), .CS_N(cs_n),
        .SCLK(sclk), .SI(si), .WP_N(wp_n), .ARRAY_BUSY(busy),
        .ARRAY_ERROR(err), .SO(so), .SO_OE(so_oe), .PROTECT_LOCK(lock),
        .ARRAY_PROTECT(bp), .WRITE_ENABLE(wr_en),
        .SOFT_RESET_PERMIT(permit), .SOFT_RESET_PULSE(pulse));
    task automatic check(input string what, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cmd(input int n, input logic [39:0] tx);
        logic [39:0] rx;
        host.frame(n, tx, rx);
    endtask : cmd
    task automatic state(input logic [3:0] exp);
        check("lock bp wr_en permit", {4'h0, lock, bp, wr_en, permit},
            {4'h0, exp});
    endtask : state
    task automatic end_of_test();
        if (failures == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        #500us;
        failures++;
        end_of_test();
    end
    // ---------------------------------------------------------
    // tests
    // ---------------------------------------------------------
    initial begin
        logic [39:0] rx;
        rstn = 1'b0;
        wp_n = 1'b1;
        busy = 1'b0;
        err = 1'b0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        state(4'b0000);
        cmd(8, 40'h99);
        check("pulses", 8'(pulses), 8'h00);
        cmd(16, 40'h3110);
        state(4'b0000);
        cmd(8, 40'h06);
        state(4'b0010);
        cmd(16, 40'h31ef);
        state(4'b0000);
        cmd(8, 40'h06);
        cmd(24, 40'h3110ef);
        state(4'b0001);
        cmd(8, 40'h99);
        check("pulses", 8'(pulses), 8'h01);
        state(4'b0001);
        cmd(8, 40'h06);
        cmd(15, 40'h1880);
        state(4'b0001);
        @(posedge clk) busy <= 1'b1;
        err <= 1'b1;
        host.frame(40, 40'h0500000000, rx);
        check("byte one", rx[31:24], 8'h31);
        check("byte two", rx[23:16], 8'h11);
        check("byte one again", rx[15:8], 8'h31);
        check("so released", {7'h0, so_oe}, 8'h00);
        @(posedge clk) busy <= 1'b0;
        for (int k = 0; k < 4 && rx[16] !== 1'b0; k++)
            host.frame(40, 40'h0500000000, rx);
        check("ready", rx[23:16], 8'h10);
        cmd(8, 40'h06);
        cmd(16, 40'h0184);
        state(4'b1101);
        @(posedge clk) wp_n <= 1'b0;
        cmd(8, 40'h06);
        cmd(16, 40'h0100);
        state(4'b1101);
        cmd(8, 40'h06);
        cmd(16, 40'h0180);
        state(4'b1101);
        @(posedge clk) wp_n <= 1'b1;
        cmd(8, 40'h06);
        cmd(12, 40'h010);
        state(4'b1101);
        cmd(8, 40'h06);
        cmd(16, 40'h0100);
        state(4'b0001);
        cmd(8, 40'h06);
        cmd(16, 40'h31ef);
        state(4'b0000);
        cmd(8, 40'h06);
        cmd(16, 40'h3110);
        state(4'b0001);
        rstn <= 1'b0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        state(4'b0000);
        cmd(8, 40'h99);
        check("pulses", 8'(pulses), 8'h01);
        end_of_test();
    end
endmodule : flash_status_write_control_tb

// File: tb/spi_host_model.sv
/* spi mode 0 host driving chip select, clock and data.
   assumes clk is the 40 MHz bench clock; sclk period 8 clk. */
`timescale 1ns/1ps
module spi_host_model (
    input wire logic clk,
    input wire logic so,
    output logic cs_n,
    output logic sclk,
    output logic si
);
    // ---------------------------------------------------------
    // one framed transfer, n bits
    // ---------------------------------------------------------
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    task automatic frame(input int n, input logic [39:0] tx,
            output logic [39:0] rx);
        rx = '0;
        @(posedge clk) cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = n - 1; i >= 0; i--) begin
            si <= tx[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (3) @(posedge clk);
            @(negedge clk) rx[i] = so;
            @(posedge clk) sclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        repeat (10) @(posedge clk);
    endtask : frame
endmodule : spi_host_model
